// >>> pkg/dmb_pkg.sv
// constants and types for the data-memory bank address generator
// Operation
// - Bank comes from primary and secondary select registers, common flag, alternate flag.
// - Save pushes both selects and both flags together; restore reloads all four.
// - Four in-bank modes: primary pair, secondary pair, direct, stack pointer.
// - Primary pair uses primary select; secondary/direct use secondary when alternate set.
// - Direct with common flag and address 0 to 7FH forces bank 0.
// - Direct with common flag and address 80 to FFH uses alternate-chosen select.
// - Select values decode by least bit only: even gives bank 0, odd bank 7.
// - Primary pair mode uses primary pointer pair as in-bank address.
// - Secondary pair mode uses secondary pointer pair as in-bank address.
// - Direct mode takes in-bank address from the 8-bit instruction immediate.
// - Stack pointer mode always addresses bank 7.
// - Push, pop, call, return and interrupt entry use stack pointer mode.
// - Stack accesses ignore address bit 0 and move two nibbles.
// - Stack pointer top and bottom bits fixed at 1; middle six count.
// - Stack pointer counts down on every push, up on every pop.
// - Stack pointer resets to 0FFH.
// - Full address is 11 bits: 3 bank bits over 8 in-bank bits.
package dmb_pkg;

  typedef enum logic [1:0] {
    DMB_MODE_PRI = 2'b00,
    DMB_MODE_SEC = 2'b01,
    DMB_MODE_DIR = 2'b10,
    DMB_MODE_STK = 2'b11
  } dmb_mode_t;

  // apb map
  localparam logic [11:0] DMB_OFS_BANK_CTRL = 12'h000;
  localparam logic [11:0] DMB_OFS_STACK_PTR = 12'h004;
  localparam logic [11:0] DMB_OFS_LAST_ADDR = 12'h008;

  // bank control fields
  localparam int DMB_BC_PRI_LSB    = 0;
  localparam int DMB_BC_SEC_LSB    = 4;
  localparam int DMB_BC_COMMON_BIT = 8;
  localparam int DMB_BC_ALT_BIT    = 9;

  // saved bank state byte layout
  localparam int DMB_SV_PRI_LSB    = 0;
  localparam int DMB_SV_SEC_LSB    = 3;
  localparam int DMB_SV_COMMON_BIT = 6;
  localparam int DMB_SV_ALT_BIT    = 7;

  // reset values and codes
  localparam logic [2:0] DMB_BSR_RESET    = 3'h0;
  localparam logic [7:0] DMB_SP_RESET     = 8'hFF;
  localparam logic [5:0] DMB_SP_CNT_RESET = 6'h3F;
  localparam logic [2:0] DMB_BANK0_CODE   = 3'h0;
  localparam logic [2:0] DMB_BANK7_CODE   = 3'h7;
  localparam logic [7:0] DMB_COMMON_LIMIT = 8'h7F;

endpackage

// >>> logic/dmb_bank_sel.sv
// combinational bank selection from mode, flags and select registers
`timescale 1ns/1ns
`default_nettype none
module dmb_bank_sel
  import dmb_pkg::*;
(
  // selection inputs
  input  wire dmb_mode_t  i_mode,
  input  wire logic [7:0] i_inbank,
  input  wire logic [2:0] i_bank_select_primary,
  input  wire logic [2:0] i_bank_select_secondary,
  input  wire logic       i_common_bank_flag,
  input  wire logic       i_alt_bank_enable_flag,
  // result
  output logic [2:0]      o_bank
);

  wire logic [2:0] alt_sel;
  wire logic [2:0] chosen_sel;
  wire logic [2:0] decoded;
  wire logic       common_low;

  assign alt_sel    = i_alt_bank_enable_flag ? i_bank_select_secondary
                                             : i_bank_select_primary;
  assign chosen_sel = (i_mode == DMB_MODE_PRI) ? i_bank_select_primary : alt_sel;
  assign decoded    = chosen_sel[0] ? DMB_BANK7_CODE : DMB_BANK0_CODE;
  assign common_low = i_common_bank_flag && (i_inbank <= DMB_COMMON_LIMIT);

  always_comb begin
    unique case (i_mode)
      DMB_MODE_STK: o_bank = DMB_BANK7_CODE;
      DMB_MODE_DIR: o_bank = common_low ? DMB_BANK0_CODE : decoded;
      DMB_MODE_PRI,
      DMB_MODE_SEC: o_bank = decoded;
    endcase
  end

endmodule
`default_nettype wire

// >>> logic/dmb_addr_gen.sv
// data-memory bank and address generator with apb register access
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dmb_addr_gen
  import dmb_pkg::*;
(
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // cpu access request
  input  wire logic        I_REQ,
  input  wire logic [1:0]  I_MODE,
  input  wire logic [7:0]  I_IMM,
  input  wire logic [7:0]  I_PRIMARY_PAIR,
  input  wire logic [7:0]  I_SECONDARY_PAIR,
  input  wire logic        I_STACK_POP,
  input  wire logic        I_BANK_STATE,
  // stack read return
  input  wire logic [7:0]  I_STACK_RDATA,
  input  wire logic        I_STACK_RVALID,
  // memory side
  output logic [10:0]      O_ADDR,
  output logic             O_ADDR_VALID,
  output logic             O_PAIR_ACCESS,
  output logic [7:0]       O_WDATA,
  output logic             O_WDATA_VALID
);

  // registers
  logic [2:0]  bank_select_primary_reg;
  logic [2:0]  bank_select_secondary_reg;
  logic        common_bank_flag_reg;
  logic        alt_bank_enable_flag_reg;
  logic [5:0]  sp_cnt_reg;
  logic        restore_pend_reg;
  logic [10:0] addr_reg;
  logic        addr_valid_reg;
  logic        pair_reg;
  logic [7:0]  wdata_reg;
  logic        wdata_valid_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // decode
  wire dmb_mode_t  mode;
  wire logic       stk_req;
  wire logic       push_req;
  wire logic       pop_req;
  wire logic       save_req;
  wire logic       restore_req;
  wire logic       restore_load;
  wire logic [5:0] sp_cnt_next;
  wire logic [5:0] sp_cnt_use;
  wire logic [7:0] stack_top_pointer;
  wire logic [7:0] stack_addr;
  wire logic [7:0] inbank;
  wire logic [2:0] bank;
  wire logic [7:0] bank_state_packed;
  wire logic       apb_access;
  wire logic       apb_wr;
  wire logic       hit_bank;
  wire logic       hit_sp;
  wire logic       hit_last;
  wire logic       hit_any;
  wire logic [31:0] rd_mux;

  assign mode         = dmb_mode_t'(I_MODE);
  assign stk_req      = I_REQ && (mode == DMB_MODE_STK);
  assign push_req     = stk_req && !I_STACK_POP;
  assign pop_req      = stk_req && I_STACK_POP;
  assign save_req     = push_req && I_BANK_STATE;
  assign restore_req  = pop_req && I_BANK_STATE;
  assign restore_load = restore_pend_reg && I_STACK_RVALID;

  // push uses current top then steps down; pop steps up then reads
  assign sp_cnt_next  = 6'(sp_cnt_reg + (pop_req ? 6'h01 : 6'h3F));
  assign sp_cnt_use   = pop_req ? sp_cnt_next : sp_cnt_reg;
  assign stack_top_pointer = {1'b1, sp_cnt_reg, 1'b1};
  assign stack_addr   = {1'b1, sp_cnt_use, 1'b0};

  assign inbank = (mode == DMB_MODE_PRI) ? I_PRIMARY_PAIR   :
                  (mode == DMB_MODE_SEC) ? I_SECONDARY_PAIR :
                  (mode == DMB_MODE_DIR) ? I_IMM            :
                                           stack_addr;

  assign bank_state_packed = {alt_bank_enable_flag_reg, common_bank_flag_reg,
                              bank_select_secondary_reg, bank_select_primary_reg};

  dmb_bank_sel u_bank_sel (
    .i_mode                  (mode),
    .i_inbank                (inbank),
    .i_bank_select_primary   (bank_select_primary_reg),
    .i_bank_select_secondary (bank_select_secondary_reg),
    .i_common_bank_flag      (common_bank_flag_reg),
    .i_alt_bank_enable_flag  (alt_bank_enable_flag_reg),
    .o_bank                  (bank)
  );

  // apb decode, one wait state per access
  assign apb_access = I_PSEL && I_PENABLE && !pready_reg;
  assign apb_wr     = I_PSEL && I_PENABLE && pready_reg && I_PWRITE && !pslverr_reg;
  assign hit_bank   = (I_PADDR == DMB_OFS_BANK_CTRL);
  assign hit_sp     = (I_PADDR == DMB_OFS_STACK_PTR);
  assign hit_last   = (I_PADDR == DMB_OFS_LAST_ADDR);
  assign hit_any    = hit_bank || hit_sp || hit_last;
  assign rd_mux = hit_bank ? {22'h00_0000, alt_bank_enable_flag_reg, common_bank_flag_reg,
                              1'b0, bank_select_secondary_reg, 1'b0, bank_select_primary_reg} :
                  hit_sp   ? {24'h00_0000, stack_top_pointer} :
                  hit_last ? {21'h00_0000, addr_reg} :
                             32'h0000_0000;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_access;
      pslverr_reg <= apb_access && !hit_any;
      prdata_reg  <= (apb_access && !I_PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // bank state: restore load wins over an apb write in the same cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      bank_select_primary_reg   <= DMB_BSR_RESET;
      bank_select_secondary_reg <= DMB_BSR_RESET;
      common_bank_flag_reg      <= 1'b0;
      alt_bank_enable_flag_reg  <= 1'b0;
    end else if (restore_load) begin
      bank_select_primary_reg   <= I_STACK_RDATA[DMB_SV_PRI_LSB +: 3];
      bank_select_secondary_reg <= I_STACK_RDATA[DMB_SV_SEC_LSB +: 3];
      common_bank_flag_reg      <= I_STACK_RDATA[DMB_SV_COMMON_BIT];
      alt_bank_enable_flag_reg  <= I_STACK_RDATA[DMB_SV_ALT_BIT];
    end else if (apb_wr && hit_bank) begin
      bank_select_primary_reg   <= I_PWDATA[DMB_BC_PRI_LSB +: 3];
      bank_select_secondary_reg <= I_PWDATA[DMB_BC_SEC_LSB +: 3];
      common_bank_flag_reg      <= I_PWDATA[DMB_BC_COMMON_BIT];
      alt_bank_enable_flag_reg  <= I_PWDATA[DMB_BC_ALT_BIT];
    end
  end

  // stack pointer: stack traffic wins over an apb write
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      sp_cnt_reg <= DMB_SP_CNT_RESET;
    end else if (stk_req) begin
      sp_cnt_reg <= sp_cnt_next;
    end else if (apb_wr && hit_sp) begin
      sp_cnt_reg <= I_PWDATA[6:1];
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      restore_pend_reg <= 1'b0;
    end else if (restore_req) begin
      restore_pend_reg <= 1'b1;
    end else if (I_STACK_RVALID) begin
      restore_pend_reg <= 1'b0;
    end
  end

  // memory-side outputs
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      addr_reg        <= 11'h000;
      addr_valid_reg  <= 1'b0;
      pair_reg        <= 1'b0;
      wdata_reg       <= 8'h00;
      wdata_valid_reg <= 1'b0;
    end else begin
      addr_valid_reg  <= I_REQ;
      pair_reg        <= stk_req;
      wdata_valid_reg <= save_req;
      if (I_REQ) begin
        addr_reg <= {bank, inbank};
      end
      if (save_req) begin
        wdata_reg <= bank_state_packed;
      end
    end
  end

  assign O_PRDATA      = prdata_reg;
  assign O_PREADY      = pready_reg;
  assign O_PSLVERR     = pslverr_reg;
  assign O_ADDR        = addr_reg;
  assign O_ADDR_VALID  = addr_valid_reg;
  assign O_PAIR_ACCESS = pair_reg;
  assign O_WDATA       = wdata_reg;
  assign O_WDATA_VALID = wdata_valid_reg;

  // checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  sequence s_restore_issue;
    restore_req ##[1:8] (restore_pend_reg && I_STACK_RVALID);
  endsequence

  sequence s_push_req;
    I_REQ && (I_MODE == 2'b11) && !I_STACK_POP;
  endsequence

  sequence s_pop_req;
    I_REQ && (I_MODE == 2'b11) && I_STACK_POP;
  endsequence

  chk_stack_bank7: assert property (
    (I_REQ && I_MODE == 2'b11) |=> (O_ADDR[10:8] == 3'h7 && O_PAIR_ACCESS && !O_ADDR[0]))
    else $error("stack access not a bank 7 pair");

  chk_primary_addr: assert property (
    (I_REQ && I_MODE == 2'b00) |=> (O_ADDR[7:0] == $past(I_PRIMARY_PAIR)
      && O_ADDR[10:8] == ($past(bank_select_primary_reg[0]) ? 3'h7 : 3'h0)))
    else $error("primary pair address or bank wrong");

  chk_secondary_addr: assert property (
    (I_REQ && I_MODE == 2'b01 && alt_bank_enable_flag_reg)
      |=> (O_ADDR == {($past(bank_select_secondary_reg[0]) ? 3'h7 : 3'h0),
                      $past(I_SECONDARY_PAIR)}))
    else $error("secondary pair address wrong");

  chk_direct_imm: assert property (
    (I_REQ && I_MODE == 2'b10) |=> (O_ADDR[7:0] == $past(I_IMM)))
    else $error("direct address not from immediate");

  chk_common_low: assert property (
    (I_REQ && I_MODE == 2'b10 && common_bank_flag_reg && !I_IMM[7])
      |=> (O_ADDR[10:8] == 3'h0))
    else $error("common low area did not force bank 0");

  chk_sp_push: assert property (
    s_push_req |=> (sp_cnt_reg == $past(sp_cnt_reg) - 6'h01)
      && (O_ADDR[6:1] == $past(sp_cnt_reg)))
    else $error("stack pointer did not step down on push");

  chk_sp_fixed: assert property (
    (apb_access && !I_PWRITE && hit_sp) |=> (O_PRDATA[7] && O_PRDATA[0]))
    else $error("stack pointer fixed bits not 1");

  chk_reset_sp: assert property (
    $fell(I_RST) |-> (stack_top_pointer == 8'hFF && bank_select_primary_reg == 3'h0))
    else $error("reset values wrong");

  chk_save_data: assert property (
    (s_push_req and I_BANK_STATE) |=> (O_WDATA_VALID && O_WDATA == $past(bank_state_packed)))
    else $error("bank state not pushed");

  chk_restore_load: assert property (
    s_restore_issue |=> (bank_select_primary_reg == $past(I_STACK_RDATA[2:0])
      && alt_bank_enable_flag_reg == $past(I_STACK_RDATA[7])))
    else $error("bank state not restored");

  chk_common_high: assert property (
    (I_REQ && I_MODE == 2'b10 && common_bank_flag_reg && I_IMM[7] && alt_bank_enable_flag_reg)
      |=> (O_ADDR[10:8] == ($past(bank_select_secondary_reg[0]) ? 3'h7 : 3'h0)))
    else $error("common high area ignored secondary select");

  chk_direct_no_alt: assert property (
    (I_REQ && I_MODE == 2'b10 && !common_bank_flag_reg && !alt_bank_enable_flag_reg)
      |=> (O_ADDR[10:8] == ($past(bank_select_primary_reg[0]) ? 3'h7 : 3'h0)))
    else $error("direct access without alternate ignored primary select");

  chk_sec_no_alt: assert property (
    (I_REQ && I_MODE == 2'b01 && !alt_bank_enable_flag_reg)
      |=> (O_ADDR[10:8] == ($past(bank_select_primary_reg[0]) ? 3'h7 : 3'h0)))
    else $error("secondary pair without alternate ignored primary select");

  chk_sp_pop: assert property (
    s_pop_req |=> ((sp_cnt_reg == $past(sp_cnt_reg) + 6'h01)
      && (O_ADDR[6:1] == sp_cnt_reg) && O_PAIR_ACCESS))
    else $error("stack pointer did not step up on pop");

  chk_reset_flags: assert property (
    $fell(I_RST) |-> (bank_select_secondary_reg == 3'h0 && !common_bank_flag_reg
      && !alt_bank_enable_flag_reg))
    else $error("bank flags not cleared by reset");

  chk_restore_pend: assert property (
    restore_req |=> restore_pend_reg)
    else $error("restore request not held pending");

  chk_save_only: assert property (
    (I_REQ && !(I_MODE == 2'b11 && !I_STACK_POP && I_BANK_STATE)) |=> !O_WDATA_VALID)
    else $error("bank state written without a save");

  chk_apb_ready: assert property (
    (I_PSEL && I_PENABLE && !O_PREADY) |=> (O_PREADY ##1 !O_PREADY))
    else $error("ready not a single pulse after one wait state");

  chk_apb_unmapped: assert property (
    (I_PSEL && I_PENABLE && !O_PREADY && !hit_any)
      |=> (O_PSLVERR && O_PRDATA == 32'h0000_0000))
    else $error("unmapped access not refused");

endmodule
`default_nettype wire

// >>> verification/dmb_core_model.sv
// behavioural stack memory on the cpu side, answering pops after a set delay
`timescale 1ns/1ns
`default_nettype none
module dmb_core_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // request side
  input  wire logic        i_req,
  input  wire logic        i_pop,
  input  wire logic [1:0]  i_delay,
  // memory side of the generator
  input  wire logic [10:0] i_addr,
  input  wire logic        i_addr_valid,
  input  wire logic        i_pair,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wdata_valid,
  // stack read return
  output logic [7:0]       o_rdata,
  output logic             o_rvalid
);
  logic [7:0]  mem [0:2047];
  logic [10:0] ra;
  logic [1:0]  cnt;
  logic        busy;
  logic        pop_q;

  always_ff @(posedge i_clk) begin
    pop_q <= i_req & i_pop;
    if (i_rst) begin
      busy     <= 1'b0;
      cnt      <= 2'h0;
      o_rvalid <= 1'b0;
      o_rdata  <= 8'h5A;
    end else begin
      o_rvalid <= 1'b0;
      // idle data never repeats the last byte
      o_rdata  <= ~o_rdata;
      if (i_wdata_valid)
        mem[i_addr] <= i_wdata;
      if (i_addr_valid && i_pair && pop_q) begin
        busy <= 1'b1;
        cnt  <= i_delay;
        ra   <= i_addr;
      end else if (busy && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (busy) begin
        busy     <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata  <= mem[ra];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/data_memory_bank_address_gen_tb_top.sv
// self-checking bench for the data-memory bank address generator
`timescale 1ns/1ns
`default_nettype none
module data_memory_bank_address_gen_tb_top;
  import dmb_pkg::*;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, perr;
  logic        req, pop, bst, srv, av, pa, wv, com, alt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ctl;
  logic [1:0]  mode, dly, m;
  logic [7:0]  imm, ppair, spair, srd, wd, sp, ib;
  logic [10:0] addr, ea;
  logic [2:0]  pri, sec;
  int          fail_count, compares;

  always #10 clk = ~clk;

  dmb_addr_gen u_dmb_addr_gen (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_REQ(req), .I_MODE(mode), .I_IMM(imm), .I_PRIMARY_PAIR(ppair),
    .I_SECONDARY_PAIR(spair), .I_STACK_POP(pop), .I_BANK_STATE(bst), .I_STACK_RDATA(srd),
    .I_STACK_RVALID(srv), .O_ADDR(addr), .O_ADDR_VALID(av), .O_PAIR_ACCESS(pa),
    .O_WDATA(wd), .O_WDATA_VALID(wv));

  dmb_core_model u_dmb_core_model (.i_clk(clk), .i_rst(rst), .i_req(req), .i_pop(pop),
    .i_delay(dly), .i_addr(addr), .i_addr_valid(av), .i_pair(pa), .i_wdata(wd),
    .i_wdata_valid(wv), .o_rdata(srd), .o_rvalid(srv));

  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      fail_count++;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // one cpu request; returns at the edge where the answer stands
  task automatic cpu(input logic [1:0] mm, input logic p, input logic b);
    @(posedge clk);
    req  <= 1'b1;
    mode <= mm;
    pop  <= p;
    bst  <= b;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    chk("addr valid", 1, av);
  endtask

  function automatic logic [2:0] exp_bank(input logic [1:0] md, input logic [7:0] a);
    logic [2:0] s;
    s = (md == DMB_MODE_PRI || !alt) ? pri : sec;
    if (md == DMB_MODE_STK)
      return DMB_BANK7_CODE;
    if (md == DMB_MODE_DIR && com && a <= DMB_COMMON_LIMIT)
      return DMB_BANK0_CODE;
    return s[0] ? DMB_BANK7_CODE : DMB_BANK0_CODE;
  endfunction

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {clk, psel, pen, pwr, req, pop, bst} = '0;
    {paddr, pwdata, mode, imm, ppair, spair, dly} = '0;
    rst = 1'b1;
    void'($urandom(53855));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, DMB_OFS_BANK_CTRL, 0);
    chk("bank ctrl reset", 0, rd);
    apb(0, DMB_OFS_STACK_PTR, 0);
    chk("sp reset", 32'h0000_00FF, rd);
    apb(0, 12'h00C, 0);
    chk("unmapped error", 1, perr);
    for (int i = 0; i < 40; i++) begin
      ctl = $urandom | ((i < 2) ? 32'h0000_0100 : 32'h0000_0000);
      {alt, com} = ctl[9:8];
      pri = ctl[2:0];
      sec = ctl[6:4];
      apb(1, DMB_OFS_BANK_CTRL, ctl);
      apb(0, DMB_OFS_BANK_CTRL, 0);
      chk("bank ctrl", {22'h0, alt, com, 1'b0, sec, 1'b0, pri}, rd);
      imm   <= (i < 2) ? 8'h7F + i[7:0] : 8'($urandom);
      ppair <= 8'($urandom);
      spair <= 8'($urandom);
      m = (i < 2) ? DMB_MODE_DIR : 2'($urandom % 3);
      cpu(m, 0, 0);
      ib = (m == DMB_MODE_PRI) ? ppair : (m == DMB_MODE_SEC) ? spair : imm;
      ea = {exp_bank(m, ib), ib};
      chk("addr", ea, addr);
      chk("pair flag", 0, pa);
    end
    apb(0, DMB_OFS_LAST_ADDR, 0);
    chk("last addr", {21'h0, ea}, rd);
    apb(1, DMB_OFS_STACK_PTR, 32'h0000_0040);
    apb(0, DMB_OFS_STACK_PTR, 0);
    chk("sp write", 32'h0000_00C1, rd);
    sp = 8'hC1;
    dly <= 2'd3;
    cpu(DMB_MODE_STK, 0, 0);
    chk("push addr", {3'h7, sp[7:1], 1'b0}, addr);
    chk("pair flag", 1, pa);
    chk("save strobe", 0, wv);
    sp = sp - 8'd2;
    apb(1, DMB_OFS_BANK_CTRL, 32'h0000_0315);
    cpu(DMB_MODE_STK, 0, 1);
    chk("save addr", {3'h7, sp[7:1], 1'b0}, addr);
    chk("save strobe", 1, wv);
    chk("saved state", {1'b1, 1'b1, 3'd1, 3'd5}, wd);
    sp = sp - 8'd2;
    apb(1, DMB_OFS_BANK_CTRL, 0);
    apb(0, DMB_OFS_STACK_PTR, 0);
    chk("sp after pushes", {24'h0, sp}, rd);
    cpu(DMB_MODE_STK, 1, 1);
    sp = sp + 8'd2;
    chk("restore addr", {3'h7, sp[7:1], 1'b0}, addr);
    for (int k = 0; k < 10 && srv !== 1'b1; k++)
      @(posedge clk);
    @(posedge clk);
    apb(0, DMB_OFS_BANK_CTRL, 0);
    chk("restored state", 32'h0000_0315, rd);
    dly <= 2'd0;
    cpu(DMB_MODE_STK, 1, 0);
    sp = sp + 8'd2;
    chk("pop addr", {3'h7, sp[7:1], 1'b0}, addr);
    apb(0, DMB_OFS_STACK_PTR, 0);
    chk("sp after pops", 32'h0000_00C1, rd);
    apb(1, DMB_OFS_BANK_CTRL, 32'h0000_0315);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, DMB_OFS_BANK_CTRL, 0);
    chk("bank ctrl reset again", 0, rd);
    apb(0, DMB_OFS_STACK_PTR, 0);
    chk("sp reset again", 32'h0000_00FF, rd);
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
